// ===== asi_dma_model.sv
`timescale 1ns/1ps
module asi_dma_model (
	// bus side
	input  logic aclk,
	input  logic dma_req,
	input  logic slow,
	// result taken
	output logic dma_read
);
	int cnt = 0;
	// each request, early or late, restarts the count, so in slow mode a request followed by another before its read is collected only once
	always @(posedge aclk) begin
		dma_read <= (cnt == 1);
		if (dma_req)
			cnt <= slow ? 6 : 1;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
endmodule

// ===== asi_pkg.sv
package asi_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_WINDOW = 8'h08;
	localparam logic [7:0] ADDR_RESULT = 8'h0c;

	// ----------------------------------------------------------------
	// status bits
	// ----------------------------------------------------------------
	localparam int BIT_WINDOW_ALARM    = 0;
	localparam int BIT_GROUP_DONE      = 1;
	localparam int BIT_INJECTED_DONE   = 2;
	localparam int BIT_INJECTED_START  = 3;
	localparam int BIT_REGULAR_START   = 4;
	localparam int BIT_RESULT_LOST     = 5;
	localparam int STATUS_W            = 6;

	// ----------------------------------------------------------------
	// control bits
	// ----------------------------------------------------------------
	localparam int BIT_POWER_ON        = 0;
	localparam int BIT_INTERNAL_EN     = 1;
	localparam int BIT_DONE_IE         = 2;
	localparam int BIT_INJ_DONE_IE     = 3;
	localparam int BIT_ALARM_IE        = 4;
	localparam int BIT_LOST_IE         = 5;
	localparam int BIT_DMA_EN          = 6;
	localparam int CTRL_W              = 7;

	// ----------------------------------------------------------------
	// field layout, reset values, channel numbers
	// ----------------------------------------------------------------
	localparam int LIMIT_W   = 12;
	localparam int HIGH_LSB  = 16;
	localparam int RESULT_W  = 16;
	localparam int CHAN_W    = 5;
	localparam logic [CHAN_W-1:0] TEMPERATURE_INPUT = 5'h17;
	localparam logic [CHAN_W-1:0] REFERENCE_INPUT   = 5'h11;
	localparam logic [STATUS_W-1:0] STATUS_RESET  = 6'h00;
	localparam logic [CTRL_W-1:0]   CTRL_RESET    = 7'h00;
	localparam logic [LIMIT_W-1:0]  LOW_RESET     = 12'h000;
	localparam logic [LIMIT_W-1:0]  HIGH_RESET    = 12'hfff;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_RESP = 2'b01
	} asi_bus_state_t;

endpackage

// ===== asi_status_irq.sv
`timescale 1ns/1ps

module asi_status_irq
	import asi_pkg::*;
(
	// clock, reset, enable
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                clk_en,
	// axi4-lite write address
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	// axi4-lite write response
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	// axi4-lite read data
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// converter events, one-cycle pulses
	input  wire logic                regular_start,
	input  wire logic                injected_start,
	input  wire logic                regular_done,
	input  wire logic                injected_done,
	input  wire logic [RESULT_W-1:0] regular_result,
	input  wire logic [LIMIT_W-1:0]  compare_value,
	input  wire logic                compare_valid,
	input  wire logic [CHAN_W-1:0]   request_channel,
	// dma
	output logic                     dma_req,
	input  wire logic                dma_read,
	// analogue control
	output logic                     converter_power_on,
	output logic                     sensor_power_up,
	output logic                     temperature_input_sel,
	output logic                     channel_allowed,
	// interrupt
	output logic                     irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	asi_bus_state_t         wr_st_ff, nxt_wr_st, rd_st_ff, nxt_rd_st;
	logic                   aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
	logic [7:0]             awaddr_ff, nxt_awaddr;
	logic [31:0]            wdata_ff, nxt_wdata;
	logic [3:0]             wstrb_ff, nxt_wstrb;
	logic [1:0]             bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0]            rdata_ff, nxt_rdata;
	logic [STATUS_W-1:0]    status_ff, nxt_status;
	logic [CTRL_W-1:0]      ctrl_ff, nxt_ctrl;
	logic [LIMIT_W-1:0]     low_ff, nxt_low, high_ff, nxt_high;
	logic [RESULT_W-1:0]    result_ff, nxt_result;
	logic                   unread_ff, nxt_unread;
	logic                   dma_req_ff, nxt_dma_req;
	logic                   irq_ff, nxt_irq;
	logic                   do_write, do_read, status_rd, result_rd;
	logic [STATUS_W-1:0]    set_ev, clr_w0;

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	// while frozen no handshake may complete: the master would see a transfer
	// or a response taken that no register ever recorded
	assign s_axi_awready = (wr_st_ff == BUS_IDLE) && !aw_got_ff && clk_en;
	assign s_axi_wready  = (wr_st_ff == BUS_IDLE) && !w_got_ff && clk_en;
	assign s_axi_bvalid  = (wr_st_ff == BUS_RESP) && clk_en;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = (rd_st_ff == BUS_IDLE) && clk_en;
	assign s_axi_rvalid  = (rd_st_ff == BUS_RESP) && clk_en;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;
	assign do_write      = (wr_st_ff == BUS_IDLE) && aw_got_ff && w_got_ff;
	assign do_read       = s_axi_arvalid && s_axi_arready;
	assign status_rd     = do_read && (s_axi_araddr == ADDR_STATUS);
	// limitation: a dma read pulse that arrives while frozen is lost
	assign result_rd     = (do_read && (s_axi_araddr == ADDR_RESULT)) || dma_read;

	// ----------------------------------------------------------------
	// flag events
	// ----------------------------------------------------------------
	// gating the sensor and reference inputs keeps the mux from selecting a dead node
	assign channel_allowed = !((request_channel == TEMPERATURE_INPUT) ||
		(request_channel == REFERENCE_INPUT)) || ctrl_ff[BIT_INTERNAL_EN];
	assign temperature_input_sel = (request_channel == TEMPERATURE_INPUT)
		&& ctrl_ff[BIT_INTERNAL_EN];
	assign sensor_power_up    = ctrl_ff[BIT_INTERNAL_EN];
	assign converter_power_on = ctrl_ff[BIT_POWER_ON];

	always_comb begin
		set_ev = '0;
		set_ev[BIT_WINDOW_ALARM]   = compare_valid &&
			((compare_value < low_ff) || (compare_value > high_ff));
		set_ev[BIT_GROUP_DONE]     = regular_done || injected_done;
		set_ev[BIT_INJECTED_DONE]  = injected_done;
		set_ev[BIT_INJECTED_START] = injected_start;
		set_ev[BIT_REGULAR_START]  = regular_start;
		set_ev[BIT_RESULT_LOST]    = regular_done && unread_ff && !result_rd;
		clr_w0 = '0;
		if (do_write && (awaddr_ff == ADDR_STATUS) && wstrb_ff[0]) begin
			clr_w0 = ~wdata_ff[STATUS_W-1:0];
		end
		clr_w0[BIT_RESULT_LOST] = status_rd;
		if (result_rd) begin
			clr_w0[BIT_GROUP_DONE] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_wr_st  = wr_st_ff;
		nxt_rd_st  = rd_st_ff;
		nxt_aw_got = aw_got_ff;
		nxt_w_got  = w_got_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata  = wdata_ff;
		nxt_wstrb  = wstrb_ff;
		nxt_bresp  = bresp_ff;
		nxt_rresp  = rresp_ff;
		nxt_rdata  = rdata_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_low    = low_ff;
		nxt_high   = high_ff;
		// address and data may come in either order; each waits in its own holding register
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_got = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_got = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		case (wr_st_ff)
			BUS_IDLE: begin
				if (do_write) begin
					nxt_aw_got = 1'b0;
					nxt_w_got  = 1'b0;
					nxt_wr_st  = BUS_RESP;
					nxt_bresp  = RESP_OKAY;
					if (awaddr_ff == ADDR_STATUS) begin
						nxt_bresp = RESP_OKAY;
					end else if (awaddr_ff == ADDR_CTRL) begin
						if (wstrb_ff[0]) begin
							nxt_ctrl = wdata_ff[CTRL_W-1:0];
						end
					end else if (awaddr_ff == ADDR_WINDOW) begin
						if (wstrb_ff[0]) nxt_low[7:0] = wdata_ff[7:0];
						if (wstrb_ff[1]) nxt_low[11:8] = wdata_ff[11:8];
						if (wstrb_ff[2]) nxt_high[7:0] = wdata_ff[23:16];
						if (wstrb_ff[3]) nxt_high[11:8] = wdata_ff[27:24];
					end else if (awaddr_ff == ADDR_RESULT) begin
						nxt_bresp = RESP_OKAY;
					end else begin
						nxt_bresp = RESP_SLVERR;
					end
				end
			end
			BUS_RESP: begin
				if (s_axi_bready) nxt_wr_st = BUS_IDLE;
			end
			default: nxt_wr_st = BUS_IDLE;
		endcase
		case (rd_st_ff)
			BUS_IDLE: begin
				if (do_read) begin
					nxt_rd_st = BUS_RESP;
					nxt_rresp = RESP_OKAY;
					nxt_rdata = '0;
					if (s_axi_araddr == ADDR_STATUS) begin
						nxt_rdata[STATUS_W-1:0] = status_ff;
					end else if (s_axi_araddr == ADDR_CTRL) begin
						nxt_rdata[CTRL_W-1:0] = ctrl_ff;
					end else if (s_axi_araddr == ADDR_WINDOW) begin
						nxt_rdata[LIMIT_W-1:0] = low_ff;
						nxt_rdata[HIGH_LSB +: LIMIT_W] = high_ff;
					end else if (s_axi_araddr == ADDR_RESULT) begin
						nxt_rdata[RESULT_W-1:0] = result_ff;
					end else begin
						nxt_rresp = RESP_SLVERR;
					end
				end
			end
			BUS_RESP: begin
				if (s_axi_rready) nxt_rd_st = BUS_IDLE;
			end
			default: nxt_rd_st = BUS_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// flags, result and requests, next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_result = result_ff;
		nxt_unread = unread_ff;
		// set wins over any clear in the same cycle
		nxt_status = (status_ff & ~clr_w0) | set_ev;
		// a single result register; a new result overwrites the old one
		if (regular_done) begin
			nxt_result = regular_result;
			nxt_unread = 1'b1;
		end else if (result_rd) begin
			nxt_unread = 1'b0;
		end
		nxt_dma_req = regular_done && ctrl_ff[BIT_DMA_EN];
		// irq follows the next flags and enables, so it lands on the edge of its cause
		nxt_irq = (nxt_status[BIT_GROUP_DONE]    && nxt_ctrl[BIT_DONE_IE])     ||
		          (nxt_status[BIT_INJECTED_DONE] && nxt_ctrl[BIT_INJ_DONE_IE]) ||
		          (nxt_status[BIT_WINDOW_ALARM]  && nxt_ctrl[BIT_ALARM_IE])    ||
		          (nxt_status[BIT_RESULT_LOST]   && nxt_ctrl[BIT_LOST_IE]);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_st_ff   <= BUS_IDLE;
			rd_st_ff   <= BUS_IDLE;
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff   <= '0;
			wstrb_ff   <= '0;
			bresp_ff   <= RESP_OKAY;
			rresp_ff   <= RESP_OKAY;
			rdata_ff   <= '0;
			ctrl_ff    <= CTRL_RESET;
			low_ff     <= LOW_RESET;
			high_ff    <= HIGH_RESET;
		end else if (clk_en) begin
			wr_st_ff   <= nxt_wr_st;
			rd_st_ff   <= nxt_rd_st;
			aw_got_ff  <= nxt_aw_got;
			w_got_ff   <= nxt_w_got;
			awaddr_ff  <= nxt_awaddr;
			wdata_ff   <= nxt_wdata;
			wstrb_ff   <= nxt_wstrb;
			bresp_ff   <= nxt_bresp;
			rresp_ff   <= nxt_rresp;
			rdata_ff   <= nxt_rdata;
			ctrl_ff    <= nxt_ctrl;
			low_ff     <= nxt_low;
			high_ff    <= nxt_high;
		end
	end

	// ----------------------------------------------------------------
	// flag, result and request registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_ff  <= STATUS_RESET;
			result_ff  <= '0;
			unread_ff  <= 1'b0;
			dma_req_ff <= 1'b0;
			irq_ff     <= 1'b0;
		end else if (clk_en) begin
			status_ff  <= nxt_status;
			result_ff  <= nxt_result;
			unread_ff  <= nxt_unread;
			dma_req_ff <= nxt_dma_req;
			irq_ff     <= nxt_irq;
		end
	end

	assign dma_req = dma_req_ff;
	assign irq     = irq_ff;

endmodule

// ===== asi_status_irq_checker.sv
`timescale 1ns/1ps
module asi_status_irq_checker
	import asi_pkg::*;
(
	// clock, reset
	input logic              aclk,
	input logic              aresetn,
	// causes
	input logic              regular_done,
	input logic              injected_done,
	input logic              compare_valid,
	input logic              dma_read,
	input logic [CHAN_W-1:0] request_channel,
	input logic              s_axi_bvalid,
	input logic              s_axi_rvalid,
	// effects
	input logic              dma_req,
	input logic              irq,
	input logic              converter_power_on,
	input logic              sensor_power_up,
	input logic              temperature_input_sel,
	input logic              channel_allowed
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic inner;
	assign inner = request_channel == TEMPERATURE_INPUT || request_channel == REFERENCE_INPUT;
	a_dma_cause: assert property (dma_req |-> $past(regular_done))
		else $error("dma request without regular completion");
	a_dma_single: assert property (dma_req && !regular_done |=> !dma_req)
		else $error("dma request too long");
	a_temp_route: assert property (temperature_input_sel ==
		(request_channel == TEMPERATURE_INPUT && sensor_power_up))
		else $error("temperature routing wrong");
	a_inner_gate: assert property (inner |-> channel_allowed == sensor_power_up)
		else $error("internal channel gating wrong");
	a_outer_open: assert property (!inner |-> channel_allowed)
		else $error("external channel blocked");
	a_irq_rise: assert property ($rose(irq) |-> s_axi_bvalid
		|| $past(regular_done || injected_done || compare_valid))
		else $error("interrupt raised without cause");
	a_irq_fall: assert property ($fell(irq) |-> s_axi_bvalid || s_axi_rvalid
		|| $past(dma_read))
		else $error("interrupt dropped without clear");
	a_power_write: assert property ($changed(converter_power_on)
		|| $changed(sensor_power_up) |-> s_axi_bvalid)
		else $error("power control changed without write");
endmodule

bind asi_status_irq asi_status_irq_checker asi_status_irq_checker_i (.aclk, .aresetn,
	.regular_done, .injected_done, .compare_valid, .dma_read, .request_channel,
	.s_axi_bvalid, .s_axi_rvalid, .dma_req, .irq, .converter_power_on,
	.sensor_power_up, .temperature_input_sel, .channel_allowed);

// ===== asi_status_irq_tb.sv
`timescale 1ns/1ps
module asi_status_irq_tb
	import asi_pkg::*;
;
	logic                aclk, aresetn, slow, dma_read, dma_req, irq, pwr, sens, tsel, allow;
	logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic                s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]          s_axi_bresp, s_axi_rresp;
	logic [7:0]          s_axi_awaddr, s_axi_araddr;
	logic [31:0]         s_axi_wdata, s_axi_rdata;
	logic [4:0]          ev_v;
	logic [LIMIT_W-1:0]  cmp;
	logic [CHAN_W-1:0]   chan;
	int                  failures = 0, checked = 0, dma_seen = 0;
	logic                ce;
	// 17.1us of sensor sampling at 25 ns a cycle, plus one spare cycle
	localparam int       SAMPLE_CYC = 685;
	asi_status_irq asi_status_irq_i (.aclk, .aresetn, .clk_en(ce), .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .regular_start(ev_v[0]), .injected_start(ev_v[1]),
		.regular_done(ev_v[2]), .injected_done(ev_v[3]), .regular_result(16'h0abc),
		.compare_value(cmp), .compare_valid(ev_v[4]), .request_channel(chan), .dma_req,
		.dma_read, .converter_power_on(pwr), .sensor_power_up(sens),
		.temperature_input_sel(tsel), .channel_allowed(allow), .irq);
	asi_dma_model asi_dma_model_i (.aclk, .dma_req, .slow, .dma_read);
	// ----------------------------------------------------------------
	// bus cycles and comparison
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(s_axi_bresp), 32'((a > ADDR_RESULT) ? RESP_SLVERR : RESP_OKAY));
		// one idle edge keeps the next call from driving bready twice in one step
		@(posedge aclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rresp", 32'(s_axi_rresp), 32'(r));
		if (r === RESP_OKAY)
			chk("rdata", s_axi_rdata, e);
		@(posedge aclk);
	endtask
	// one-cycle event, then time for flag and interrupt to land
	task automatic ev(input logic [4:0] v);
		ev_v <= v;
		@(posedge aclk);
		ev_v <= 5'h00;
		repeat (2) @(posedge aclk);
	endtask
	task automatic t_reset();
		wr(8'h10, 32'hffffffff);
		rc(ADDR_STATUS, 32'h0, RESP_OKAY);
		rc(ADDR_CTRL, 32'h0, RESP_OKAY);
		rc(ADDR_WINDOW, 32'h0fff0000, RESP_OKAY);
		rc(8'h10, 32'h0, RESP_SLVERR);
	endtask
	task automatic t_flags();
		wr(ADDR_WINDOW, 32'hf2000100);
		wr(ADDR_CTRL, 32'h3c);
		ev(5'h03);
		chk("irq", 32'(irq), 32'h0);
		cmp <= 12'h200;
		ev(5'h1c);
		rc(ADDR_STATUS, 32'h1e, RESP_OKAY);
		chk("irq", 32'(irq), 32'h1);
		rc(ADDR_RESULT, 32'h0abc, RESP_OKAY);
		wr(ADDR_STATUS, 32'hffffffff);
		rc(ADDR_STATUS, 32'h1c, RESP_OKAY);
		wr(ADDR_STATUS, 32'h0);
		rc(ADDR_STATUS, 32'h0, RESP_OKAY);
		chk("irq", 32'(irq), 32'h0);
	endtask
	task automatic t_irq();
		logic [4:0]  evs [4] = '{5'h04, 5'h08, 5'h10, 5'h04};
		logic [31:0] sts [4] = '{32'h02, 32'h06, 32'h01, 32'h22};
		cmp <= 12'h0ff;
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL, 32'h4 << i);
			ev(evs[i]);
			if (i == 3)
				ev(evs[i]);
			chk("irq", 32'(irq), 32'h1);
			rc(ADDR_STATUS, sts[i], RESP_OKAY);
			wr(ADDR_STATUS, 32'h0);
			@(posedge aclk);
			chk("irq", 32'(irq), 32'h0);
		end
	endtask
	task automatic t_dma();
		int n;
		rc(ADDR_RESULT, 32'h0abc, RESP_OKAY);
		wr(ADDR_CTRL, 32'h40);
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			n = dma_seen;
			ev(5'h04);
			repeat (8) @(posedge aclk);
			chk("dma count", 32'(dma_seen - n), 32'h1);
			rc(ADDR_STATUS, 32'h0, RESP_OKAY);
		end
		ev(5'h08);
		chk("dma count", 32'(dma_seen - n), 32'h1);
		wr(ADDR_STATUS, 32'h0);
		wr(ADDR_CTRL, 32'h0);
		ev(5'h04);
		chk("dma count", 32'(dma_seen - n), 32'h1);
		rc(ADDR_RESULT, 32'h0abc, RESP_OKAY);
		rc(ADDR_STATUS, 32'h0, RESP_OKAY);
	endtask
	task automatic t_chan();
		logic [CHAN_W-1:0] chs [3] = '{TEMPERATURE_INPUT, REFERENCE_INPUT, 5'h05};
		for (int e = 0; e < 2; e++) begin
			wr(ADDR_CTRL, 32'(3 * e));
			chk("power", 32'({pwr, sens}), 32'(3 * e));
			for (int j = 0; j < 3; j++) begin
				chan <= chs[j];
				@(posedge aclk);
				chk("route", 32'(tsel), 32'(j == 0 && e == 1));
				chk("allowed", 32'(allow), 32'(j == 2 || e == 1));
			end
		end
		chan <= TEMPERATURE_INPUT;
		repeat (SAMPLE_CYC) @(posedge aclk);
		ev(5'h05);
		rc(ADDR_STATUS, 32'h12, RESP_OKAY);
	endtask
	task automatic t_hold();
		ce <= 1'b0;
		@(posedge aclk);
		chk("frozen ready", 32'({s_axi_awready, s_axi_wready, s_axi_arready}), 32'h0);
		ev(5'h01);
		ce <= 1'b1;
		rc(ADDR_STATUS, 32'h0, RESP_OKAY);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk)
		if (dma_req === 1'b1)
			dma_seen++;
	// whole run is about nine hundred cycles; this only cuts a hang short
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		close_out();
	end
	initial begin
		{aresetn, slow, ev_v, cmp, chan, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		ce = 1'b1;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_hold();
		t_flags();
		t_irq();
		t_dma();
		t_chan();
		close_out();
	end
endmodule
